// ---- logic/acpi_ec_host_mailbox_regs.sv ----
// ec-side mailbox registers over axi4-lite, with a host write fifo
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mailbox_defs.svh"

// plain ring fifo, valid/ready both sides
module mailbox_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input  wire logic             aclk,      // system clock
  input  wire logic             aresetn,   // sync reset, low
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write offered
  output var  logic             in_ready,  // room left
  output var  logic [WIDTH-1:0] out_data,  // head word
  output var  logic             out_valid, // head present
  input  wire logic             out_ready  // consumer takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg, wp_next, rp_reg, rp_next;
  logic             push, pop, in_ready_reg, in_ready_next;

  // the wrap-bit pointers only work for a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("fifo depth must be a power of two");
  end

  // pointers carry one wrap bit so full and empty are exact; room is registered
  always_comb begin
    in_ready      = in_ready_reg;
    out_valid     = wp_reg != rp_reg;
    out_data      = mem[rp_reg[AW-1:0]];
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    wp_next       = wp_reg + (AW + 1)'(push);
    rp_next       = rp_reg + (AW + 1)'(pop);
    in_ready_next = (wp_next[AW] == rp_next[AW]) || (wp_next[AW-1:0] != rp_next[AW-1:0]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_reg       <= '0;
      rp_reg       <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      wp_reg       <= wp_next;
      rp_reg       <= rp_next;
      in_ready_reg <= in_ready_next;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge aclk) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule

module acpi_ec_host_mailbox_regs #(
  parameter int ADDR_W     = 12,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                       aclk,          // system clock
  input  wire logic                       aresetn,       // system reset, sync, low
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,  // write address
  input  wire logic                       s_axi_awvalid, // write address valid
  output var  logic                       s_axi_awready, // write address taken
  input  wire logic [31:0]                s_axi_wdata,   // write data
  input  wire logic [3:0]                 s_axi_wstrb,   // byte enables
  input  wire logic                       s_axi_wvalid,  // write data valid
  output var  logic                       s_axi_wready,  // write data taken
  output var  logic [1:0]                 s_axi_bresp,   // write response
  output var  logic                       s_axi_bvalid,  // write response valid
  input  wire logic                       s_axi_bready,  // response accepted
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,  // read address
  input  wire logic                       s_axi_arvalid, // read address valid
  output var  logic                       s_axi_arready, // read address taken
  output var  logic [31:0]                s_axi_rdata,   // read data
  output var  logic [1:0]                 s_axi_rresp,   // read response
  output var  logic                       s_axi_rvalid,  // read data valid
  input  wire logic                       s_axi_rready,  // read data accepted
  input  wire mailbox_pkg::host_word_type host_wr_word,  // host command or data
  input  wire logic                       host_wr_valid, // host write offered
  output var  logic                       host_wr_ready, // fifo has room
  input  wire logic                       host_rd_pulse, // host consumed ec word
  output var  logic [31:0]                ec_to_host_word, // word the host reads
  output var  logic [7:0]                 host_status,   // host read-only status
  output var  logic [7:0]                 host_byte_ctl  // host read-only control
);
  if (ADDR_W < 11) begin
    $error("address too narrow for register map");
  end

  // word index from byte address; high bits must be clear to hit
  function automatic logic [8:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = (a >> 11) == '0 ? a[10:2] : 9'h000;
  endfunction

  logic [7:0]  e2h_reg [4];
  logic [7:0]  e2h_next [4];
  logic [31:0] h2e_reg, h2e_next;
  logic [7:0]  status_reg, status_next;
  logic        four_reg, four_next;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic        awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_go, rd_go, drain;
  logic [8:0]  widx, ridx;
  mailbox_pkg::host_word_type fifo_out;
  logic        fifo_valid;

  // host writes queue here; the queue stalls while input-full is set
  mailbox_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (host_wr_word),
    .in_valid  (host_wr_valid),
    .in_ready  (host_wr_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (!status_reg[`ST_IBF])
  );

  // axi handshakes: address and data latched apart, joined for the write
  always_comb begin
    wr_go        = aw_full_reg && w_full_reg && !bvalid_reg;
    rd_go        = s_axi_arvalid && arready_reg;
    aw_full_next = wr_go ? 1'b0 : aw_full_reg || (s_axi_awvalid && awready_reg);
    w_full_next  = wr_go ? 1'b0 : w_full_reg || (s_axi_wvalid && wready_reg);
    awaddr_next  = (s_axi_awvalid && awready_reg) ? s_axi_awaddr : awaddr_reg;
    wdata_next   = (s_axi_wvalid && wready_reg) ? s_axi_wdata : wdata_reg;
    wstrb_next   = (s_axi_wvalid && wready_reg) ? s_axi_wstrb : wstrb_reg;
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
    bvalid_next  = bvalid_reg ? !s_axi_bready : wr_go;
    rvalid_next  = rvalid_reg ? !s_axi_rready : rd_go;
    arready_next = !rvalid_next;
    widx         = reg_idx(awaddr_reg);
    ridx         = reg_idx(s_axi_araddr);
  end

  // register contents; set events are applied last so they beat clears
  always_comb begin
    e2h_next    = e2h_reg;
    h2e_next    = h2e_reg;
    status_next = status_reg;
    four_next   = four_reg;
    bresp_next  = bresp_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    drain       = fifo_valid && !status_reg[`ST_IBF];
    if (wr_go) begin
      bresp_next = `RESP_OKAY;
      unique case (widx)
        `IDX_E2H_B0: if (wstrb_reg[0]) e2h_next[0] = wdata_reg[7:0];
        `IDX_E2H_B1, `IDX_E2H_B2, `IDX_E2H_B3:
          if (four_reg && wstrb_reg[0]) e2h_next[widx[1:0]] = wdata_reg[7:0];
        `IDX_STATUS: if (wstrb_reg[0])
          status_next = (status_reg & ~`ST_EC_WR_MASK) | (wdata_reg[7:0] & `ST_EC_WR_MASK);
        `IDX_BYTECTL: if (wstrb_reg[0]) four_next = wdata_reg[0];
        `IDX_H2E_B0, `IDX_H2E_B1, `IDX_H2E_B2, `IDX_H2E_B3: ; // written only by the host
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rresp_next = `RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (ridx)
        `IDX_E2H_B0: rdata_next[7:0] = e2h_reg[0];
        `IDX_E2H_B1, `IDX_E2H_B2, `IDX_E2H_B3: if (four_reg) rdata_next[7:0] = e2h_reg[ridx[1:0]];
        `IDX_STATUS: rdata_next[7:0] = status_reg;
        `IDX_BYTECTL: rdata_next[0] = four_reg;
        `IDX_H2E_B0: rdata_next[7:0] = h2e_reg[7:0];
        `IDX_H2E_B1, `IDX_H2E_B2, `IDX_H2E_B3:
          if (four_reg) rdata_next[7:0] = h2e_reg[8*ridx[1:0] +: 8];
        default: rresp_next = `RESP_SLVERR;
      endcase
      // consuming the host word frees the input side
      if (four_reg ? ridx == `IDX_H2E_B3 : ridx == `IDX_H2E_B0) status_next[`ST_IBF] = 1'b0;
    end
    // host read clears output-full; host power state is not an input here
    if (host_rd_pulse) status_next[`ST_OBF] = 1'b0;
    if (drain) begin
      h2e_next                = fifo_out.data;
      status_next[`ST_IBF]    = 1'b1;
      status_next[`ST_CMD]    = fifo_out.is_cmd;
    end
    if (wr_go && wstrb_reg[0] && (four_reg ? widx == `IDX_E2H_B3 : widx == `IDX_E2H_B0))
      status_next[`ST_OBF] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e2h_reg     <= '{default: `BYTE_RESET};
      h2e_reg     <= 32'h0000_0000;
      status_reg  <= `ST_RESET;
      four_reg    <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      bresp_reg   <= 2'h0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      e2h_reg     <= e2h_next;
      h2e_reg     <= h2e_next;
      status_reg  <= status_next;
      four_reg    <= four_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      rvalid_reg  <= rvalid_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
      bresp_reg   <= bresp_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // outputs; host aliases are the very same flops, so no lag
  always_comb begin
    s_axi_awready   = awready_reg;
    s_axi_wready    = wready_reg;
    s_axi_bvalid    = bvalid_reg;
    s_axi_bresp     = bresp_reg;
    s_axi_arready   = arready_reg;
    s_axi_rvalid    = rvalid_reg;
    s_axi_rresp     = rresp_reg;
    s_axi_rdata     = rdata_reg;
    ec_to_host_word = {e2h_reg[3], e2h_reg[2], e2h_reg[1], e2h_reg[0]};
    host_status     = status_reg;
    host_byte_ctl   = {7'h00, four_reg};
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ec_wr(logic [8:0] i);
    wr_go && wstrb_reg[0] && widx == i;
  endsequence
  sequence ec_rd(logic [8:0] i);
    rd_go && ridx == i;
  endsequence

  obf_one_byte_a: assert property (ec_wr(`IDX_E2H_B0) ##0 !four_reg |=> status_reg[`ST_OBF])
    else $error("byte 0 write did not set output-full");
  obf_four_byte_a: assert property (ec_wr(`IDX_E2H_B3) ##0 four_reg |=> status_reg[`ST_OBF])
    else $error("byte 3 write did not set output-full");
  byte_drop_a: assert property (ec_wr(`IDX_E2H_B1) ##0 !four_reg |=> $stable(e2h_reg[1]))
    else $error("one-byte mode stored upper byte");
  byte_zero_a: assert property (ec_rd(`IDX_E2H_B2) ##0 !four_reg |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("one-byte mode upper read not zero");
  ibf_clear_a: assert property (ec_rd(`IDX_H2E_B3) ##0 four_reg |=> !status_reg[`ST_IBF])
    else $error("byte 3 read did not clear input-full");
  ibf_one_byte_a: assert property (ec_rd(`IDX_H2E_B0) ##0 !four_reg && status_reg[`ST_IBF] |=> !status_reg[`ST_IBF])
    else $error("byte 0 read did not clear input-full");
  flag_keep_a: assert property ($fell(status_reg[`ST_OBF]) |-> $past(host_rd_pulse))
    else $error("output-full fell without host read");
  cmd_ro_a: assert property ($changed(status_reg[`ST_CMD]) |-> $past(drain))
    else $error("command marker changed without host write");
  user_flags_a: assert property (ec_wr(`IDX_STATUS) |=> status_reg[7:4] == $past(wdata_reg[7:4])
    && status_reg[`ST_USER_LO] == $past(wdata_reg[2]))
    else $error("status write not stored");
  ctl_alias_a: assert property (ec_wr(`IDX_BYTECTL) |=> host_byte_ctl == {7'h00, $past(wdata_reg[0])})
    else $error("byte control alias wrong");
  bresp_time_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response late");
endmodule
`default_nettype wire

// ---- logic/mailbox_defs.svh ----
// register indexes, field positions and reset values of the ec mailbox view
`ifndef MAILBOX_DEFS_SVH
`define MAILBOX_DEFS_SVH
`define IDX_E2H_B0 9'h100
`define IDX_E2H_B1 9'h101
`define IDX_E2H_B2 9'h102
`define IDX_E2H_B3 9'h103
`define IDX_STATUS 9'h104
`define IDX_BYTECTL 9'h105
`define IDX_H2E_B0 9'h108
`define IDX_H2E_B1 9'h109
`define IDX_H2E_B2 9'h10a
`define IDX_H2E_B3 9'h10b
`define ST_OBF 0
`define ST_IBF 1
`define ST_USER_LO 2
`define ST_CMD 3
`define ST_BURST 4
`define ST_SCI 5
`define ST_SMI 6
`define ST_USER_HI 7
`define ST_EC_WR_MASK 8'hf4
`define ST_RESET 8'h00
`define BYTE_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- logic/mailbox_pkg.sv ----
// shared types of the ec mailbox register block
`default_nettype none
package mailbox_pkg;
  // one host write to the mailbox: a command or a data word
  typedef struct packed {
    logic        is_cmd;
    logic [31:0] data;
  } host_word_type;
endpackage
`default_nettype wire

// ---- verification/acpi_ec_host_mailbox_regs_bench.sv ----
// self-checking bench of the ec mailbox registers over axi4-lite
`timescale 1ns/100ps
`default_nettype none
`include "mailbox_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module acpi_ec_host_mailbox_regs_bench;
  logic                       aclk = 1'b0;
  logic                       aresetn = 1'b0;
  logic [11:0]                s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]                s_axi_wdata = '0, s_axi_rdata, ec_to_host_word, rdat;
  logic [3:0]                 s_axi_wstrb = '0;
  logic                       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ok;
  logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]                 s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]                 host_status, host_byte_ctl;
  logic                       host_wr_ready, host_wr_valid, host_rd_pulse;
  mailbox_pkg::host_word_type host_wr_word;
  int                         errors = 0, tests_run = 0, cycles = 0;

  acpi_ec_host_mailbox_regs #(.ADDR_W(12), .FIFO_DEPTH(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .host_wr_word, .host_wr_valid, .host_wr_ready, .host_rd_pulse, .ec_to_host_word,
    .host_status, .host_byte_ctl);
  host_model host (.aclk, .host_wr_ready, .host_wr_word, .host_wr_valid, .host_rd_pulse);

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // register index to byte address, one word per register
  function automatic logic [11:0] adr(input logic [8:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  // address and data offered together, each dropped once taken; only the run's timeout ends a wait
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    axi_rd(a);
    `CHK("rdata", {24'h0, e}, rdat)
    `CHK("rresp", `RESP_OKAY, rsp)
  endtask

  // poll status until the input-full flag shows, bounded
  task automatic wait_ibf(input logic [7:0] e);
    for (int n = 0; n < 20; n++) begin
      axi_rd(adr(`IDX_STATUS));
      if (rdat[`ST_IBF] === 1'b1) break;
    end
    `CHK("status", {24'h0, e}, rdat)
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // e2h bytes, status and byte control clear after reset
    for (int i = 0; i < 6; i++) rd_chk(adr(`IDX_E2H_B0 + 9'(i)), 8'h00);
    `CHK("host_status", 8'h00, host_status)
    // reserved control bits read zero, host copy follows
    axi_wr(adr(`IDX_BYTECTL), 32'hff);
    rd_chk(adr(`IDX_BYTECTL), 8'h01);
    `CHK("host_byte_ctl", 8'h01, host_byte_ctl)
    // four-byte mode: only the top byte sets output-full
    for (int i = 0; i < 4; i++) begin
      axi_wr(adr(`IDX_E2H_B0 + 9'(i)), 32'h11 * (i + 1));
      `CHK("obf", 1'(i == 3), host_status[`ST_OBF])
    end
    `CHK("ec_to_host_word", 32'h44332211, ec_to_host_word)
    rd_chk(adr(`IDX_E2H_B2), 8'h33);
    host.consume();
    `CHK("host_status", 8'h00, host_status)
    // writable status bits only; flags and cmd stay with hardware
    axi_wr(adr(`IDX_STATUS), 32'hff);
    rd_chk(adr(`IDX_STATUS), 8'hf4);
    `CHK("host_status", 8'hf4, host_status)
    axi_wr(adr(`IDX_STATUS), 32'h00);
    // a host command word, read lowest byte first, cleared by the top byte
    host.push(1'b1, 32'haabbccdd, ok);
    `CHK("push", 1'b1, ok)
    wait_ibf(8'h0a);
    for (int i = 0; i < 4; i++) begin
      rd_chk(adr(`IDX_H2E_B0 + 9'(i)), 8'(32'haabbccdd >> (8 * i)));
      `CHK("ibf", 1'(i < 3), host_status[`ST_IBF])
    end
    // one-byte mode: upper bytes dropped, byte 0 sets output-full
    axi_wr(adr(`IDX_BYTECTL), 32'h00);
    axi_wr(adr(`IDX_E2H_B1), 32'h55);
    rd_chk(adr(`IDX_E2H_B1), 8'h00);
    `CHK("host_status", 8'h08, host_status)
    axi_wr(adr(`IDX_E2H_B0), 32'h66);
    `CHK("host_status", 8'h09, host_status)
    host.consume();
    // one word held in the mailbox and eight queued fill the buffer
    for (int i = 0; i < 9; i++) begin
      host.push(1'b0, 32'h100 + i, ok);
      `CHK("push", 1'b1, ok)
    end
    repeat (2) @(posedge aclk);
    `CHK("host_wr_ready", 1'b0, host_wr_ready)
    for (int i = 0; i < 9; i++) begin
      wait_ibf(8'h02);
      rd_chk(adr(`IDX_H2E_B1), 8'h00);
      rd_chk(adr(`IDX_H2E_B0), 8'(i));
    end
    rd_chk(adr(`IDX_STATUS), 8'h00);
    // unmapped place answers with an error and reads zero
    axi_wr(12'h418, 32'h1);
    `CHK("bresp", `RESP_SLVERR, rsp)
    axi_rd(12'h418);
    `CHK("rresp", `RESP_SLVERR, rsp)
    `CHK("rdata", 32'h0, rdat)
    // a reset in mid-run is what clears a pending full flag
    axi_wr(adr(`IDX_BYTECTL), 32'h01);
    axi_wr(adr(`IDX_E2H_B3), 32'h77);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(adr(`IDX_STATUS), 8'h00);
    rd_chk(adr(`IDX_BYTECTL), 8'h00);
    rd_chk(adr(`IDX_E2H_B3), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire

// ---- verification/host_model.sv ----
// host side model: offers host words to the mailbox and consumes the ec word
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                       aclk,          // system clock
  input  wire logic                       host_wr_ready, // fifo has room
  output var  mailbox_pkg::host_word_type host_wr_word,  // word offered
  output var  logic                       host_wr_valid, // word valid
  output var  logic                       host_rd_pulse  // ec word consumed
);
  initial begin
    host_wr_word = '0;
    host_wr_valid = 1'b0;
    host_rd_pulse = 1'b0;
  end

  // hold the word until taken or the 50-cycle wait runs out, then garble it so a late sample cannot pass
  task automatic push(input logic is_cmd, input logic [31:0] data, output logic ok);
    int n;
    n = 0;
    @(posedge aclk);
    host_wr_word <= '{is_cmd, data};
    host_wr_valid <= 1'b1;
    @(posedge aclk);
    while (host_wr_ready !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    ok = (host_wr_ready === 1'b1);
    host_wr_valid <= 1'b0;
    host_wr_word <= ~host_wr_word;
  endtask

  // one-cycle read of the ec word by the host
  task automatic consume();
    @(posedge aclk);
    host_rd_pulse <= 1'b1;
    @(posedge aclk);
    host_rd_pulse <= 1'b0;
    // one more edge so the caller sees the cleared flag, not the old one
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire
